/* File: bench/stm_checker.sv */
`default_nettype none
module stm_checker
  import stm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic lid_removed_in,
  input wire logic [23:0] nvm_pwr_in,
  input wire logic [3:0] status_led,
  input wire logic station_green,
  input wire logic station_red,
  input wire logic menu_active,
  input wire stm_cmd_s cmd,
  input wire logic [23:0] power_on_count,
  input wire logic nvm_write
);
  timeunit 1ns;
  timeprecision 1ps;
  // Slack covers sync stages and a blink phase restart
  localparam int BLINK_MAX = BLINK_TICKS * CYC_PER_MS + 20;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  logic quit_w;
  assign quit_w = menu_active && status_led == SEL_EDGE;
  logic red_q;
  logic [31:0] red_hold_r;
  // Cycles in quit since the red lamp last changed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      red_q <= 1'b0;
      red_hold_r <= 32'h00000000;
    end else begin
      red_q <= station_red;
      if (!quit_w || station_red != red_q) red_hold_r <= 32'h00000000;
      else red_hold_r <= red_hold_r + 32'h00000001;
    end
  end
  AST_IDLE_QUIET: assert property (!lid_removed_in && !menu_active && !$past(menu_active)
    |-> status_led == 4'h0 && cmd == 7'h00) else $error("Idle menu shows LEDs or commands");
  AST_LID_CLOSE: assert property ($fell(lid_removed_in) |-> ##[1:6] !menu_active)
    else $error("Menu stayed open with lid installed");
  AST_IDLE_GREEN: assert property ($fell(menu_active) |-> ##[0:3]
    (station_green && !station_red) [*4]) else $error("Station not solid green after exit");
  AST_QUIT_NO_GREEN: assert property (quit_w |-> !station_green)
    else $error("Green station lamp during quit");
  AST_QUIT_BLINK: assert property (red_hold_r <= 32'(BLINK_MAX))
    else $error("Red station lamp not blinking in quit");
  AST_APPLY_LEDS: assert property (nvm_write |-> ##[0:3]
    (status_led == SEL_TOP || status_led == SEL_LEFT)) else $error("Apply left wrong LED code");
  AST_CENTRE: assert property (cmd.centre_line |->
    (status_led == SEL_TOP || status_led == SEL_LEFT)) else $error("Centring line outside margin");
  AST_LOAD_PULSE: assert property (cmd.load |=> !cmd.load)
    else $error("Load command longer than one cycle");
  AST_LOOP_START: assert property (cmd.loop_start |-> status_led == SEL_LOOP)
    else $error("Loop check started from wrong test");
  AST_LOOP_STOP: assert property (cmd.loop_stop |-> ##[0:3] status_led == SEL_LOOP)
    else $error("Loop test not shown after stop");
  AST_POWER_COUNT: assert property ($past(sys_rst) |=>
    power_on_count == nvm_pwr_in + 24'h000001) else $error("Power-on count not stepped");
  COV_APPLY: cover property (nvm_write);
  COV_LOOP: cover property (cmd.loop_start);
  COV_QUIT: cover property ($fell(menu_active));
endmodule : stm_checker
bind stm_menu stm_checker #(.CYC_PER_MS(CYC_PER_MS)) stm_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .lid_removed_in(lid_removed_in), .nvm_pwr_in(nvm_pwr_in),
  .status_led(status_led), .station_green(station_green), .station_red(station_red),
  .menu_active(menu_active), .cmd(cmd), .power_on_count(power_on_count),
  .nvm_write(nvm_write));
`default_nettype wire

/* File: bench/stm_menu_bench.sv */
`default_nettype none
module stm_menu_bench;
  import stm_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CYC = 2;
  typedef struct {
    int ms;
    logic [3:0] led;
  } stm_row_s;
  logic clk, sys_rst, lid_removed_in, char_printed, loop_ok, bar_in, eject_done;
  logic loop_result_valid, loop_pass, station_green, station_red, menu_active, nvm_write;
  logic [3:0] status_led;
  logic [15:0] fw_level;
  logic [23:0] power_on_count;
  logic [31:0] char_count;
  logic [7:0] top_margin, left_margin;
  stm_cmd_s cmd;
  logic [7:0] nvm_top = 8'h05;
  logic [7:0] nvm_left = 8'hFE;
  logic [23:0] nvm_pwr = 24'h00012F;
  logic [31:0] nvm_chars = 32'h0000A000;
  int err_count = 0;
  int total_checks = 0;
  stm_row_s rows [42];
  // Firmware level value is arbitrary
  stm_menu #(.CYC_PER_MS(CYC), .FW_LEVEL(16'h5A3C)) stm_menu_inst (
    .clk(clk), .sys_rst(sys_rst), .bar_in(bar_in), .lid_removed_in(lid_removed_in),
    .eject_done(eject_done), .loop_result_valid(loop_result_valid), .loop_pass(loop_pass),
    .char_printed(char_printed), .nvm_top_in(nvm_top), .nvm_left_in(nvm_left),
    .nvm_pwr_in(nvm_pwr), .nvm_chars_in(nvm_chars), .status_led(status_led),
    .station_green(station_green), .station_red(station_red), .menu_active(menu_active),
    .cmd(cmd), .fw_level(fw_level), .power_on_count(power_on_count),
    .char_count(char_count), .top_margin(top_margin), .left_margin(left_margin),
    .nvm_write(nvm_write));
  stm_operator #(.CYC(CYC)) stm_operator_inst (
    .clk(clk), .cmd(cmd), .loop_ok(loop_ok), .bar_in(bar_in), .eject_done(eject_done),
    .loop_result_valid(loop_result_valid), .loop_pass(loop_pass));
  // Stored margins written back on apply
  always @(posedge clk) begin
    if (nvm_write) begin
      nvm_top <= top_margin;
      nvm_left <= left_margin;
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic reopen();
    lid_removed_in = 1'b0;
    tick(10);
    lid_removed_in = 1'b1;
    chk_led(SEL_FIRST);
  endtask : reopen
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t %s", $time, what);
    end
  endtask : chk_val
  task automatic chk_led(input logic [3:0] exp);
    int n;
    n = 0;
    while (status_led !== exp && n < 300) begin
      tick(1);
      n++;
    end
    chk_val(status_led, exp, "status LEDs");
    if (n >= 300) close_out();
  endtask : chk_led
  // Index 0 watches green, 1 red; the other colour must stay dark
  task automatic chk_blink(input int idx);
    int flips;
    logic [1:0] st, was;
    flips = 0;
    was = {station_red, station_green};
    repeat (BLINK_TICKS * CYC * 3) begin
      tick(1);
      st = {station_red, station_green};
      if (st[idx] !== was[idx]) flips++;
      if (st[1 - idx] !== 1'b0) flips = -999;
      was = st;
    end
    chk_val(flips >= 2, 1'b1, "station blink");
  endtask : chk_blink
  task automatic run_rows(input int first, input int last);
    for (int i = first; i <= last; i++) begin
      stm_operator_inst.press(rows[i].ms);
      chk_led(rows[i].led);
    end
  endtask : run_rows
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    close_out();
  end
  initial begin
    rows = '{'{60, 4'h2}, '{60, 4'h3}, '{60, 4'h4}, '{60, 4'h5}, '{60, 4'h6}, '{60, 4'h7},
      '{60, 4'h8}, '{1500, 4'h8}, '{10, 4'h8}, '{60, 4'h9}, '{60, 4'h1}, '{60, 4'h2},
      '{60, 4'h3}, '{60, 4'h4}, '{60, 4'hF}, '{60, 4'hC}, '{60, 4'hB}, '{60, 4'hA},
      '{60, 4'h9}, '{60, 4'h0}, '{60, 4'h1}, '{60, 4'h2}, '{60, 4'h3}, '{60, 4'h2},
      '{60, 4'h3}, '{60, 4'h4}, '{60, 4'h5}, '{60, 4'h6}, '{60, 4'h7}, '{60, 4'h8},
      '{60, 4'h9}, '{60, 4'hA}, '{60, 4'hB}, '{60, 4'hC}, '{60, 4'h1}, '{60, 4'h2},
      '{60, 4'h3}, '{60, 4'h4}, '{60, 4'h5}, '{60, 4'h6}, '{60, 4'hF}, '{60, 4'hE}};
    sys_rst = 1'b1;
    lid_removed_in = 1'b0;
    char_printed = 1'b0;
    loop_ok = 1'b1;
    tick(8);
    chk_val({status_led, station_green, station_red, menu_active, cmd}, 14'h0000, "reset");
    sys_rst = 1'b0;
    tick(4);
    chk_val(power_on_count, 24'h000130, "power count");
    chk_val(fw_level, 16'h5A3C, "firmware level");
    chk_val({top_margin, left_margin}, 16'h05FE, "margin load");
    char_printed = 1'b1;
    tick(3);
    char_printed = 1'b0;
    tick(2);
    chk_val(char_count, 32'h0000A003, "char count");
    $display("reset test done");
    lid_removed_in = 1'b1;
    chk_led(SEL_FIRST);
    run_rows(0, 9);
    stm_operator_inst.press(2100);
    chk_led(SEL_TOP);
    chk_blink(0);
    stm_operator_inst.press(60);
    chk_led(4'h0);
    chk_val(stm_operator_inst.n_centre, 1, "centring line");
    run_rows(10, 22);
    stm_operator_inst.press(2100);
    chk_led(SEL_TOP);
    chk_val(top_margin, 8'h08, "top margin applied");
    $display("top margin test done");
    lid_removed_in = 1'b0;
    tick(10);
    chk_val({menu_active, status_led}, 5'h00, "menu closed");
    chk_val(top_margin, 8'h08, "margin kept");
    lid_removed_in = 1'b1;
    chk_led(SEL_FIRST);
    run_rows(23, 33);
    stm_operator_inst.press(2100);
    chk_blink(0);
    stm_operator_inst.press(60);
    chk_led(SEL_LOOP);
    loop_ok = 1'b0;
    stm_operator_inst.press(2100);
    chk_blink(1);
    stm_operator_inst.press(60);
    chk_led(SEL_LOOP);
    chk_val(stm_operator_inst.n_stop, 2, "loop stopped");
    $display("loopback test done");
    stm_operator_inst.press(60);
    chk_led(SEL_EDGE);
    chk_blink(1);
    lid_removed_in = 1'b0;
    tick(10);
    chk_val({menu_active, status_led, station_red, station_green}, 7'h01, "quit");
    $display("quit test done");
    reopen();
    run_rows(23, 29);
    stm_operator_inst.press(2100);
    chk_led(SEL_LEFT);
    stm_operator_inst.press(60);
    chk_led(4'h0);
    chk_val(stm_operator_inst.n_centre, 2, "left centring line");
    run_rows(34, 41);
    stm_operator_inst.press(2100);
    chk_led(SEL_LEFT);
    chk_val(left_margin, 8'hF8, "left margin applied");
    $display("left margin test done");
    reopen();
    run_rows(23, 31);
    stm_operator_inst.press(2100);
    chk_blink(0);
    stm_operator_inst.press(60);
    chk_led(SEL_ACOUST);
    chk_val(stm_operator_inst.n_iso, 1, "iso pattern");
    reopen();
    run_rows(23, 32);
    stm_operator_inst.press(2100);
    stm_operator_inst.press(60);
    chk_led(SEL_USAGE);
    chk_val(stm_operator_inst.n_rep, 1, "usage report");
    $display("print tests done");
    sys_rst = 1'b1;
    nvm_pwr = 24'h00FFFF;
    tick(8);
    sys_rst = 1'b0;
    tick(4);
    chk_val(power_on_count, 24'h010000, "power count after reset");
    chk_val({top_margin, left_margin}, 16'h08F8, "margins after reset");
    chk_led(SEL_FIRST);
    $display("second reset test done");
    close_out();
  end
endmodule : stm_menu_bench
`default_nettype wire

/* File: bench/stm_operator.sv */
`default_nettype none
module stm_operator
  import stm_pkg::*;
#(
  parameter int CYC = 2
) (
  input wire logic clk,
  input wire stm_cmd_s cmd,
  input wire logic loop_ok,
  output logic bar_in,
  output logic eject_done,
  output logic loop_result_valid,
  output logic loop_pass
);
  timeunit 1ns;
  timeprecision 1ps;
  int ej = 0;
  int lp = 0;
  int n_centre = 0;
  int n_stop = 0;
  int n_iso = 0;
  int n_rep = 0;
  initial begin
    bar_in = 1'b0;
    eject_done = 1'b0;
    loop_result_valid = 1'b0;
    loop_pass = 1'b0;
  end
  task automatic press(input int ms);
    @(posedge clk);
    #1 bar_in = 1'b1;
    repeat (ms * CYC) @(posedge clk);
    #1 bar_in = 1'b0;
    repeat (40 * CYC) @(posedge clk);
    #1;
  endtask : press
  always @(posedge clk) begin
    eject_done <= (ej == 1);
    loop_result_valid <= (lp == 1);
    // Toggling outside a result so a stale level never reads as valid
    loop_pass <= (lp == 1) ? loop_ok : ~loop_pass;
    ej <= cmd.load ? 8 : (ej > 0 ? ej - 1 : 0);
    lp <= cmd.loop_start ? 30 : (lp > 0 ? lp - 1 : 0);
    n_centre <= n_centre + int'(cmd.centre_line);
    n_stop <= n_stop + int'(cmd.loop_stop);
    n_iso <= n_iso + int'(cmd.iso_pattern);
    n_rep <= n_rep + int'(cmd.report);
  end
endmodule : stm_operator
`default_nettype wire

/* File: verilog/stm_menu.sv */
// Operation
// - Menu runs only while the lid is removed.
// - Short press under one second is a hit; hit advances test selection.
// - Hold over two seconds enters test; margin/acoustic/usage blink green.
// - Top-margin test shows LEDs on, off, off, on.
// - Hit in top-margin test loads, prints centring line, ejects, shows setting.
// - Step 2/180 inch; three right LEDs magnitude, left LED sign, all lit exit.
// - Hits cycle zero, +1..+4, exit, -4..-1, zero.
// - Hold applies shown increment to top margin; LEDs return to test code.
// - Acoustic test on, off, on, off; hit loads and prints ISO pattern.
// - Usage test on, off, on, on; hit loads and prints report.
// - Keep firmware level, power-on count, character count, both margins.
// - Loopback on, on, off, off; hold runs check, green pass, red fail.
// - Hit stops loopback; LEDs still show loopback.
// - Quit all on: station blinks red, LEDs show edge-detector entry.
// - Lid reinstalled after quit ends menu, station solid green.
// - Left-margin test on, off, off, off; magnitude up to six.
`default_nettype none
module stm_menu
  import stm_pkg::*;
#(
  parameter int unsigned CYC_PER_MS = MS_CYCLES,
  parameter logic [15:0] FW_LEVEL = 16'h0100 // Arbitrary value
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic bar_in,
  input wire logic lid_removed_in,
  input wire logic eject_done,
  input wire logic loop_result_valid,
  input wire logic loop_pass,
  input wire logic char_printed,
  input wire logic [7:0] nvm_top_in,
  input wire logic [7:0] nvm_left_in,
  input wire logic [23:0] nvm_pwr_in,
  input wire logic [31:0] nvm_chars_in,
  output logic [3:0] status_led,
  output logic station_green,
  output logic station_red,
  output logic menu_active,
  output stm_cmd_s cmd,
  output logic [15:0] fw_level,
  output logic [23:0] power_on_count,
  output logic [31:0] char_count,
  output logic [7:0] top_margin,
  output logic [7:0] left_margin,
  output logic nvm_write
);
  // Divider is 16 bits wide
  if (CYC_PER_MS < 2 || CYC_PER_MS > 65536) begin : g_bad_div
    $error("stm_menu: CYC_PER_MS out of range");
  end
  typedef enum logic [2:0] {
    ST_IDLE, ST_BROWSE, ST_ENTERED, ST_PRINTING, ST_ADJUST, ST_LOOP, ST_QUIT
  } stm_state_e;
  stm_state_e state_r;
  logic [15:0] div_r;
  logic tick_ms, blink_tick, blink_ph_r;
  logic [7:0] blink_cnt_r;
  logic lid1_r, lid2_r, loaded_r;
  logic hit, hold;
  logic [3:0] sel_r, adj_led_r;
  logic adj_left_r;
  logic [1:0] loop_res_r;
  stm_station_s stn;

  function automatic logic [3:0] next_sel(input logic [3:0] s);
    logic [3:0] n;
    n = s + 4'h1;
    if (n == SEL_EDGE || n == 4'hE) n = SEL_QUIT;
    if (s == SEL_QUIT) n = SEL_FIRST;
    return n;
  endfunction : next_sel

  // Cyclic increment table, sign on left LED
  function automatic logic [3:0] next_inc(input logic [3:0] v, input logic [3:0] mx);
    logic [3:0] n;
    n = 4'h0;
    if (v == LED_EXIT) n = {1'b1, mx[2:0]};
    else if (!v[3]) n = (v[2:0] == mx[2:0]) ? LED_EXIT : v + 4'h1;
    else n = (v[2:0] == 3'h1) ? 4'h0 : v - 4'h1;
    return n;
  endfunction : next_inc

  function automatic logic [7:0] apply_inc(input logic [7:0] m, input logic [3:0] v);
    logic [7:0] r;
    r = m;
    if (v != LED_EXIT) r = v[3] ? m - {5'h00, v[2:0]} : m + {5'h00, v[2:0]};
    return r;
  endfunction : apply_inc

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r <= 16'h0000;
      tick_ms <= 1'b0;
    end else begin
      tick_ms <= (div_r == 16'(CYC_PER_MS - 1));
      div_r <= (div_r == 16'(CYC_PER_MS - 1)) ? 16'h0000 : div_r + 16'h0001;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt_r <= 8'h00;
      blink_ph_r <= 1'b0;
    end else if (tick_ms) begin
      if (blink_cnt_r == 8'(BLINK_TICKS - 1)) begin
        blink_cnt_r <= 8'h00;
        blink_ph_r <= ~blink_ph_r;
      end else begin
        blink_cnt_r <= blink_cnt_r + 8'h01;
      end
    end
  end
  assign blink_tick = blink_ph_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lid1_r <= 1'b0;
      lid2_r <= 1'b0;
    end else begin
      lid1_r <= lid_removed_in;
      lid2_r <= lid1_r;
    end
  end

  stm_press_timer stm_press_timer_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_ms(tick_ms),
    .bar_in(bar_in),
    .hit(hit),
    .hold(hold)
  );

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      sel_r <= SEL_FIRST;
      adj_led_r <= 4'h0;
      adj_left_r <= 1'b0;
      loop_res_r <= 2'b00;
      cmd <= '0;
    end else begin
      cmd <= '0;
      case (state_r)
        ST_IDLE: begin
          if (lid2_r) begin
            state_r <= ST_BROWSE;
            sel_r <= SEL_FIRST;
          end
        end
        ST_BROWSE: begin
          if (hit) begin
            sel_r <= next_sel(sel_r);
            if (next_sel(sel_r) == SEL_QUIT) state_r <= ST_QUIT;
          end else if (hold) begin
            cmd.enter_test <= 1'b1;
            if (sel_r == SEL_LOOP) begin
              cmd.loop_start <= 1'b1;
              loop_res_r <= 2'b00;
              state_r <= ST_LOOP;
            end else begin
              state_r <= ST_ENTERED;
            end
          end
        end
        ST_ENTERED: begin
          if (hit) begin
            cmd.load <= 1'b1;
            state_r <= ST_PRINTING;
            if (sel_r == SEL_TOP || sel_r == SEL_LEFT) cmd.centre_line <= 1'b1;
            if (sel_r == SEL_ACOUST) cmd.iso_pattern <= 1'b1;
            if (sel_r == SEL_USAGE) cmd.report <= 1'b1;
          end
        end
        ST_PRINTING: begin
          if (eject_done) begin
            adj_led_r <= 4'h0;
            adj_left_r <= (sel_r == SEL_LEFT);
            state_r <= (sel_r == SEL_TOP || sel_r == SEL_LEFT) ? ST_ADJUST : ST_ENTERED;
          end
        end
        ST_ADJUST: begin
          if (hit) begin
            adj_led_r <= next_inc(adj_led_r, adj_left_r ? LEFT_MAX : TOP_MAX);
          end else if (hold) begin
            state_r <= ST_ENTERED;
          end
        end
        ST_LOOP: begin
          if (loop_result_valid) loop_res_r <= {1'b1, loop_pass};
          if (hit) begin
            cmd.loop_stop <= 1'b1;
            state_r <= ST_BROWSE;
          end
        end
        ST_QUIT: begin
          if (!lid2_r) begin
            state_r <= ST_IDLE;
          end else if (hit) begin
            sel_r <= next_sel(sel_r);
            state_r <= ST_BROWSE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
      if (!lid2_r && state_r != ST_QUIT && state_r != ST_IDLE) state_r <= ST_IDLE;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      top_margin <= MARGIN_RST;
      left_margin <= MARGIN_RST;
      nvm_write <= 1'b0;
    end else begin
      nvm_write <= 1'b0;
      // Reload after reset too, the lid may already be off
      if (!loaded_r || (state_r == ST_IDLE && !lid2_r && !menu_active)) begin
        top_margin <= nvm_top_in;
        left_margin <= nvm_left_in;
      end
      if (state_r == ST_ADJUST && hold && !hit && adj_led_r != LED_EXIT) begin
        nvm_write <= 1'b1;
        if (adj_left_r) left_margin <= apply_inc(left_margin, adj_led_r);
        else top_margin <= apply_inc(top_margin, adj_led_r);
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      loaded_r <= 1'b0;
      power_on_count <= 24'h000000;
      char_count <= 32'h00000000;
      fw_level <= 16'h0000;
    end else begin
      fw_level <= FW_LEVEL;
      if (!loaded_r) begin
        loaded_r <= 1'b1;
        power_on_count <= nvm_pwr_in + 24'h000001;
        char_count <= nvm_chars_in;
      end else if (char_printed) begin
        char_count <= char_count + 32'h00000001;
      end
    end
  end

  always_comb begin
    stn = '0;
    case (state_r)
      ST_ENTERED, ST_PRINTING, ST_ADJUST: begin
        stn.blink = 1'b1;
        stn.color = STN_GREEN;
      end
      ST_LOOP: begin
        // pass green, fail red
        // Dark until the port check reports
        stn.blink = 1'b1;
        if (loop_res_r[1]) stn.color = loop_res_r[0] ? STN_GREEN : STN_RED;
      end
      ST_QUIT: begin
        stn.blink = 1'b1;
        stn.color = STN_RED;
      end
      ST_IDLE: begin
        stn.color = STN_GREEN;
      end
      default: stn = '0;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_led <= 4'h0;
      station_green <= 1'b0;
      station_red <= 1'b0;
      menu_active <= 1'b0;
    end else begin
      menu_active <= (state_r != ST_IDLE);
      station_green <= (stn.color == STN_GREEN) && (!stn.blink || blink_tick);
      station_red <= (stn.color == STN_RED) && (!stn.blink || blink_tick);
      if (state_r == ST_ADJUST) status_led <= adj_led_r;
      else if (state_r == ST_QUIT) status_led <= SEL_EDGE;
      else if (state_r == ST_IDLE) status_led <= 4'h0;
      else status_led <= sel_r;
    end
  end
endmodule : stm_menu
`default_nettype wire

/* File: verilog/stm_pkg.sv */
`default_nettype none
package stm_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned HIT_MAX_MS = 1000;
  localparam int unsigned HOLD_MIN_MS = 2000;
  localparam int unsigned DEBOUNCE_MS = 20;
  localparam int unsigned BLINK_MS = 250;
  localparam int unsigned MS_CYCLES = CLK_HZ / 1000;
  localparam int unsigned HIT_MAX_TICKS = HIT_MAX_MS;
  localparam int unsigned HOLD_MIN_TICKS = HOLD_MIN_MS + 1;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS;
  localparam int unsigned BLINK_TICKS = BLINK_MS;
  // Margin step is 2/180 inch (0.282 mm); adjust values count these steps
  localparam int unsigned STEP_NUM = 2;
  localparam int unsigned STEP_DEN = 180;
  localparam logic [3:0] SEL_LEFT = 4'h8;
  localparam logic [3:0] SEL_TOP = 4'h9;
  localparam logic [3:0] SEL_ACOUST = 4'hA;
  localparam logic [3:0] SEL_USAGE = 4'hB;
  localparam logic [3:0] SEL_LOOP = 4'hC;
  localparam logic [3:0] SEL_QUIT = 4'hF;
  localparam logic [3:0] SEL_EDGE = 4'hD;
  localparam logic [3:0] SEL_FIRST = 4'h1;
  localparam logic [3:0] LED_EXIT = 4'hF;
  localparam logic [3:0] TOP_MAX = 4'h4;
  localparam logic [3:0] LEFT_MAX = 4'h6;
  localparam logic [7:0] MARGIN_RST = 8'h00;
  typedef enum logic [1:0] {STN_OFF, STN_GREEN, STN_RED} stm_color_e;
  typedef struct packed {
    logic blink;
    logic [1:0] color;
  } stm_station_s;
  typedef struct packed {
    logic load;
    logic centre_line;
    logic iso_pattern;
    logic report;
    logic loop_start;
    logic loop_stop;
    logic enter_test;
  } stm_cmd_s;
endpackage : stm_pkg
`default_nettype wire

/* File: verilog/stm_press_timer.sv */
`default_nettype none
module stm_press_timer
  import stm_pkg::*;
#(
  parameter int unsigned DB_TICKS = DEBOUNCE_TICKS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tick_ms,
  input wire logic bar_in,
  output logic hit,
  output logic hold
);
  if (DB_TICKS < 1 || DB_TICKS > 255) begin : g_bad_db
    $error("stm_press_timer: bad debounce");
  end
  logic sync1_r, sync2_r, clean_r, held_r;
  logic [7:0] db_r;
  logic [11:0] dur_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= bar_in;
      sync2_r <= sync1_r;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      db_r <= 8'h00;
      clean_r <= 1'b0;
    end else if (sync2_r == clean_r) begin
      db_r <= 8'h00;
    end else if (tick_ms) begin
      if (db_r == 8'(DB_TICKS - 1)) begin
        clean_r <= sync2_r;
        db_r <= 8'h00;
      end else begin
        db_r <= db_r + 8'h01;
      end
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dur_r <= 12'h000;
      held_r <= 1'b0;
      hit <= 1'b0;
      hold <= 1'b0;
    end else begin
      hit <= 1'b0;
      hold <= 1'b0;
      if (clean_r) begin
        if (tick_ms && dur_r != 12'hFFF) dur_r <= dur_r + 12'h001;
        if (!held_r && dur_r >= 12'(HOLD_MIN_TICKS)) begin
          hold <= 1'b1;
          held_r <= 1'b1;
        end
      end else begin
        if (dur_r != 12'h000 && dur_r < 12'(HIT_MAX_TICKS) && !held_r) hit <= 1'b1;
        dur_r <= 12'h000;
        held_r <= 1'b0;
      end
    end
  end
endmodule : stm_press_timer
`default_nettype wire
